// ==== rtl/gpc_ports.sv ====
// Three GPIO ports with pull-ups, change detection and an edge interrupt, behind AXI4-Lite.
// Assumes pins arrive asynchronously; peripheral override inputs are on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module gpc_ports
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [gpc_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [gpc_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [5:0] firstPortIn,
    output logic [5:0] firstPortOut,
    output logic [5:0] firstPortOeN,
    input wire logic [7:0] secondPortIn,
    output logic [7:0] secondPortOut,
    output logic [7:0] secondPortOeN,
    output logic [7:0] secondPortPullupEn,
    input wire logic [4:0] thirdPortIn,
    output logic [4:0] thirdPortOut,
    output logic [4:0] thirdPortOeN,
    input wire logic [4:0] thirdPeriphSel,
    input wire logic [4:0] thirdPeriphDrive,
    input wire logic [4:0] thirdPeriphData,
    output logic timerClockPin,
    output logic portChangeFlag,
    output logic extIntFlag,
    output logic wakeFromHalt
);
    typedef struct packed {
        logic [gpc_pkg::ADDR_W-1:0] awAddr;
        logic awHeld;
        logic [7:0] wData;
        logic wStrb0;
        logic wHeld;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [1:0] rResp;
        logic [7:0] rData;
        logic [5:0] firstLatch;
        logic [5:0] firstDir;
        logic [7:0] secondLatch;
        logic [7:0] secondDir;
        logic [4:0] thirdLatch;
        logic [4:0] thirdDir;
        logic [7:0] option;
        logic [2:0] analogCfg;
        logic changeFlag;
        logic extFlag;
        logic changeEnable;
        logic extEnable;
        logic [3:0] snapshot;
        logic [5:0] firstSync1;
        logic [5:0] firstSync2;
        logic [7:0] secondSync1;
        logic [7:0] secondSync2;
        logic [4:0] thirdSync1;
        logic [4:0] thirdSync2;
        logic extPrev;
    } gpc_state_t;

    gpc_state_t s;
    gpc_state_t next_s;
    logic [3:0] mismatchBits;
    logic mismatch;
    logic extEdge;
    logic [5:0] firstPinRead;

    function automatic logic [7:0] gpc_third_pack(input logic [4:0] v);
        return {v[4:3], 3'b000, v[2:0]};
    endfunction

    function automatic logic [4:0] gpc_third_unpack(input logic [7:0] v);
        return {v[7:6], v[2:0]};
    endfunction

    // Upper-nibble inputs against the snapshot; output pins are masked off
    assign mismatchBits = (s.secondSync2[7:4] ^ s.snapshot) & s.secondDir[7:4];
    assign mismatch = |mismatchBits;
    // Edge select: one picks rising, zero picks falling
    assign extEdge = s.option[gpc_pkg::OPT_EDGE_BIT]
                   ? (s.secondSync2[0] & ~s.extPrev)
                   : (~s.secondSync2[0] & s.extPrev);
    // Pins left analog read as zero until software selects digital
    assign firstPinRead = (s.analogCfg[2:1] == gpc_pkg::ANALOG_DIGITAL_HI)
                        ? s.firstSync2
                        : (s.firstSync2 & ~gpc_pkg::ANALOG_PIN_MASK);

    always_comb
    begin
        logic [7:0] widx;
        logic [7:0] ridx;
        logic portTouched;
        logic [7:0] intRead;
        widx = s.awAddr[9:2];
        ridx = araddr[9:2];
        portTouched = 1'b0;
        intRead = 8'h00;
        intRead[gpc_pkg::INT_CHANGE_FLAG_BIT] = s.changeFlag;
        intRead[gpc_pkg::INT_EXT_FLAG_BIT] = s.extFlag;
        intRead[gpc_pkg::INT_CHANGE_EN_BIT] = s.changeEnable;
        intRead[gpc_pkg::INT_EXT_EN_BIT] = s.extEnable;
        next_s = s;
        next_s.firstSync1 = firstPortIn;
        next_s.firstSync2 = s.firstSync1;
        next_s.secondSync1 = secondPortIn;
        next_s.secondSync2 = s.secondSync1;
        next_s.thirdSync1 = thirdPortIn;
        next_s.thirdSync2 = s.thirdSync1;
        next_s.extPrev = s.secondSync2[0];
        if (awvalid && awready)
        begin
            next_s.awAddr = awaddr;
            next_s.awHeld = 1'b1;
        end
        if (wvalid && wready)
        begin
            next_s.wData = wdata[7:0];
            next_s.wStrb0 = wstrb[0];
            next_s.wHeld = 1'b1;
        end
        if (s.bValid && bready)
        begin
            next_s.bValid = 1'b0;
        end
        // Write executes once both halves are held; bus stalls until the response drains
        if (s.awHeld && s.wHeld && !s.bValid)
        begin
            next_s.awHeld = 1'b0;
            next_s.wHeld = 1'b0;
            next_s.bValid = 1'b1;
            next_s.bResp = gpc_pkg::RESP_OKAY;
            if (s.awAddr[11:10] != 2'b00)
            begin
                next_s.bResp = gpc_pkg::RESP_SLVERR;
            end
            else if (widx == gpc_pkg::IDX_FIRST_DATA)
            begin
                // Writes land in the latch; reads see pins, so bit ops act as read-modify-write
                if (s.wStrb0)
                    next_s.firstLatch = s.wData[5:0];
            end
            else if (widx == gpc_pkg::IDX_SECOND_DATA)
            begin
                portTouched = 1'b1;
                if (s.wStrb0)
                    next_s.secondLatch = s.wData;
            end
            else if (widx == gpc_pkg::IDX_THIRD_DATA)
            begin
                if (s.wStrb0)
                    next_s.thirdLatch = gpc_third_unpack(s.wData);
            end
            else if (widx == gpc_pkg::IDX_OPTION)
            begin
                if (s.wStrb0)
                    next_s.option = s.wData;
            end
            else if (widx == gpc_pkg::IDX_FIRST_DIR)
            begin
                if (s.wStrb0)
                    next_s.firstDir = s.wData[5:0];
            end
            else if (widx == gpc_pkg::IDX_SECOND_DIR)
            begin
                if (s.wStrb0)
                    next_s.secondDir = s.wData;
            end
            else if (widx == gpc_pkg::IDX_THIRD_DIR)
            begin
                // Stored value is kept even under override, so a read-modify-write
                // would copy the peripheral's state only if software read the pins
                if (s.wStrb0)
                    next_s.thirdDir = gpc_third_unpack(s.wData);
            end
            else if (widx == gpc_pkg::IDX_ANALOG_CFG)
            begin
                if (s.wStrb0)
                    next_s.analogCfg = s.wData[2:0];
            end
            else if (widx == gpc_pkg::IDX_INT_CTRL)
            begin
                if (s.wStrb0)
                begin
                    next_s.changeFlag = s.wData[gpc_pkg::INT_CHANGE_FLAG_BIT];
                    next_s.extFlag = s.wData[gpc_pkg::INT_EXT_FLAG_BIT];
                    next_s.changeEnable = s.wData[gpc_pkg::INT_CHANGE_EN_BIT];
                    next_s.extEnable = s.wData[gpc_pkg::INT_EXT_EN_BIT];
                end
            end
            else
            begin
                next_s.bResp = gpc_pkg::RESP_SLVERR;
            end
        end
        if (s.rValid && rready)
        begin
            next_s.rValid = 1'b0;
        end
        if (arvalid && arready)
        begin
            next_s.rValid = 1'b1;
            next_s.rResp = gpc_pkg::RESP_OKAY;
            next_s.rData = 8'h00;
            // Narrow registers fill the low bits, the third port bits 7,6,2,1,0; the rest reads zero
            if (araddr[11:10] != 2'b00)
                next_s.rResp = gpc_pkg::RESP_SLVERR;
            else if (ridx == gpc_pkg::IDX_FIRST_DATA)
                next_s.rData = {2'b00, firstPinRead};
            else if (ridx == gpc_pkg::IDX_SECOND_DATA)
            begin
                next_s.rData = s.secondSync2;
                portTouched = 1'b1;
            end
            else if (ridx == gpc_pkg::IDX_THIRD_DATA)
                next_s.rData = gpc_third_pack(s.thirdSync2);
            else if (ridx == gpc_pkg::IDX_OPTION)
                next_s.rData = s.option;
            else if (ridx == gpc_pkg::IDX_FIRST_DIR)
                next_s.rData = {2'b00, s.firstDir};
            else if (ridx == gpc_pkg::IDX_SECOND_DIR)
                next_s.rData = s.secondDir;
            else if (ridx == gpc_pkg::IDX_THIRD_DIR)
                next_s.rData = gpc_third_pack(s.thirdDir);
            else if (ridx == gpc_pkg::IDX_ANALOG_CFG)
                next_s.rData = {5'b00000, s.analogCfg};
            else if (ridx == gpc_pkg::IDX_INT_CTRL)
                next_s.rData = intRead;
            else
                next_s.rResp = gpc_pkg::RESP_SLVERR;
        end
        // Snapshot takes the pin levels seen by the access, ending the mismatch
        if (portTouched)
            next_s.snapshot = s.secondSync2[7:4];
        // Sets come after any software write so they win in the same cycle
        if (mismatch)
            next_s.changeFlag = 1'b1;
        if (extEdge)
            next_s.extFlag = 1'b1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.option <= gpc_pkg::RST_OPTION;
            s.secondDir <= gpc_pkg::RST_SECOND_DIR;
            s.secondLatch <= gpc_pkg::RST_SECOND_LATCH;
            s.firstDir <= gpc_pkg::RST_FIRST_DIR;
            s.firstLatch <= gpc_pkg::RST_FIRST_LATCH;
            s.thirdDir <= gpc_pkg::RST_THIRD_DIR;
            s.thirdLatch <= gpc_pkg::RST_THIRD_LATCH;
            s.analogCfg <= gpc_pkg::RST_ANALOG;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign awready = !s.awHeld && !s.bValid;
    assign wready = !s.wHeld && !s.bValid;
    assign bvalid = s.bValid;
    assign bresp = s.bResp;
    assign arready = !s.rValid;
    assign rvalid = s.rValid;
    assign rresp = s.rResp;
    assign rdata = {24'h000000, s.rData};

    // Open-drain bit only ever pulls low
    assign firstPortOut = {s.firstLatch[5], 1'b0, s.firstLatch[3:0]};
    assign firstPortOeN = {s.firstDir[5],
                           s.firstDir[gpc_pkg::OPEN_DRAIN_BIT]
                           | s.firstLatch[gpc_pkg::OPEN_DRAIN_BIT],
                           s.firstDir[3:0]};
    // Timer clock taps the synchronised pin, so it is usable even while the pin drives
    assign timerClockPin = s.firstSync2[gpc_pkg::OPEN_DRAIN_BIT];

    assign secondPortOut = s.secondLatch;
    assign secondPortOeN = s.secondDir;
    // Pull-ups only on input pins, all under one enable
    assign secondPortPullupEn = {8{~s.option[gpc_pkg::OPT_PULLUP_N_BIT]}} & s.secondDir;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_third
            // Override holds only while the peripheral stays selected
            assign thirdPortOeN[gi] = thirdPeriphSel[gi] ? ~thirdPeriphDrive[gi] : s.thirdDir[gi];
            assign thirdPortOut[gi] = thirdPeriphSel[gi] ? thirdPeriphData[gi] : s.thirdLatch[gi];
        end
    endgenerate

    assign portChangeFlag = s.changeFlag;
    assign extIntFlag = s.extFlag;
    // Wake is a level; the core decides whether it is halted
    assign wakeFromHalt = (s.changeFlag & s.changeEnable) | (s.extFlag & s.extEnable);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_pullup_output_off: assert property
        ((secondPortPullupEn & ~secondPortOeN) == 8'h00)
        else $error("pull-up active on an output pin");
    chk_pullup_global_off: assert property
        (s.option[gpc_pkg::OPT_PULLUP_N_BIT] |-> secondPortPullupEn == 8'h00)
        else $error("pull-up active while globally disabled");
    chk_drive_latch: assert property
        (s.awHeld && s.wHeld && !s.bValid && s.wStrb0 && s.awAddr[11:10] == 2'b00
         && s.awAddr[9:2] == gpc_pkg::IDX_SECOND_DATA
         |=> secondPortOut == $past(s.wData))
        else $error("written latch value not on the pins");
    chk_change_sets_flag: assert property (mismatch |=> portChangeFlag)
        else $error("mismatch did not set change flag");
    chk_change_excludes_out: assert property
        (s.secondDir[7:4] == 4'h0 |-> !mismatch)
        else $error("output pin caused mismatch");
    chk_snapshot_on_read: assert property
        (arvalid && arready && araddr[11:10] == 2'b00 && araddr[9:2] == gpc_pkg::IDX_SECOND_DATA
         |=> s.snapshot == $past(s.secondSync2[7:4]))
        else $error("snapshot not refreshed by read");
    chk_ext_rise: assert property
        (s.option[gpc_pkg::OPT_EDGE_BIT] && s.secondSync2[0] && !s.extPrev
         |=> extIntFlag)
        else $error("selected edge did not set external flag");
    chk_open_drain: assert property
        (!firstPortOeN[gpc_pkg::OPEN_DRAIN_BIT]
         |-> !firstPortOut[gpc_pkg::OPEN_DRAIN_BIT])
        else $error("open-drain pin driven high");
    chk_third_override: assert property
        (((thirdPortOeN ^ ~thirdPeriphDrive) & thirdPeriphSel) == 5'h00)
        else $error("peripheral override ignored");
    chk_read_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    cov_change_flag: cover property ($rose(portChangeFlag));
    cov_ext_flag: cover property ($rose(extIntFlag));
    cov_second_write: cover property
        (s.awHeld && s.wHeld && s.awAddr[9:2] == gpc_pkg::IDX_SECOND_DATA);
    cov_wake: cover property ($rose(wakeFromHalt));
endmodule
`default_nettype wire

// ==== inc/gpc_pkg.sv ====
// Constants for the three-port GPIO block: register indices, field positions and reset values.
// Assumes a single core clock and an AXI4-Lite master that uses byte address = 4 * index.
// Contract
// - Second port is eight bits with direction
// - Direction one floats the second-port pin
// - Direction zero drives the output latch
// - Option bit 7 low enables all pull-ups
// - Output pins never get a pull-up
// - Pull-ups start disabled after power-on
// - Only upper four input pins detect change
// - Compare inputs against snapshot from last read
// - OR of mismatches sets change flag
// - Port change may wake halted processor
// - Persisting mismatch keeps setting the flag
// - Any second-port data access refreshes snapshot
// - Lowest pin is edge-selectable external interrupt
// - Third port has five individually directed pins
// - Enabled peripheral overrides third-port direction
// - First port latch and direction reset values
// - Second port direction and option reset ones
// - Unimplemented bits always read as zero
// - Port reads pins, writes go to latch
// - First port bit 4 open drain, timer input
// - Shared analog pins start as analog inputs
`default_nettype none
package gpc_pkg;
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_FIRST_DATA = 8'h05;
    localparam logic [7:0] IDX_SECOND_DATA = 8'h06;
    localparam logic [7:0] IDX_THIRD_DATA = 8'h07;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_FIRST_DIR = 8'h85;
    localparam logic [7:0] IDX_SECOND_DIR = 8'h86;
    localparam logic [7:0] IDX_THIRD_DIR = 8'h87;
    localparam logic [7:0] IDX_ANALOG_CFG = 8'h9f;
    localparam logic [7:0] IDX_INT_CTRL = 8'hf0;
    localparam logic [7:0] RST_OPTION = 8'hff;
    localparam logic [7:0] RST_SECOND_DIR = 8'hff;
    localparam logic [7:0] RST_SECOND_LATCH = 8'h00;
    localparam logic [5:0] RST_FIRST_DIR = 6'h3f;
    localparam logic [5:0] RST_FIRST_LATCH = 6'h00;
    localparam logic [4:0] RST_THIRD_DIR = 5'h1f;
    localparam logic [4:0] RST_THIRD_LATCH = 5'h00;
    localparam logic [2:0] RST_ANALOG = 3'h0;
    localparam int OPT_PULLUP_N_BIT = 7;
    localparam int OPT_EDGE_BIT = 6;
    localparam int INT_CHANGE_FLAG_BIT = 0;
    localparam int INT_EXT_FLAG_BIT = 1;
    localparam int INT_CHANGE_EN_BIT = 3;
    localparam int INT_EXT_EN_BIT = 4;
    localparam int OPEN_DRAIN_BIT = 4;
    localparam logic [1:0] ANALOG_DIGITAL_HI = 2'h3;
    localparam logic [5:0] ANALOG_PIN_MASK = 6'h2f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the three-port GPIO block, driving AXI4-Lite and the pins directly.
// Assumes byte address = 4 * register index and the interrupt control register at its index.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [5:0] firstPortIn = 6'h3f;
    logic [5:0] firstPortOut, firstPortOeN;
    logic [7:0] secondPortIn = 8'h00;
    logic [7:0] secondPortOut, secondPortOeN, secondPortPullupEn;
    logic [4:0] thirdPortIn = 5'h00, thirdPeriphSel = 5'h00;
    logic [4:0] thirdPeriphDrive = 5'h00, thirdPeriphData = 5'h00;
    logic [4:0] thirdPortOut, thirdPortOeN;
    logic timerClockPin, portChangeFlag, extIntFlag, wakeFromHalt;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] rstIdx [5];
    logic [7:0] rstVal [5];

    gpc_ports dut (.sys_clk(sys_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .firstPortIn(firstPortIn), .firstPortOut(firstPortOut), .firstPortOeN(firstPortOeN),
        .secondPortIn(secondPortIn), .secondPortOut(secondPortOut),
        .secondPortOeN(secondPortOeN), .secondPortPullupEn(secondPortPullupEn),
        .thirdPortIn(thirdPortIn), .thirdPortOut(thirdPortOut), .thirdPortOeN(thirdPortOeN),
        .thirdPeriphSel(thirdPeriphSel), .thirdPeriphDrive(thirdPeriphDrive),
        .thirdPeriphData(thirdPeriphData), .timerClockPin(timerClockPin),
        .portChangeFlag(portChangeFlag), .extIntFlag(extIntFlag), .wakeFromHalt(wakeFromHalt));

    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // A hang anywhere ends the run through the same report
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("[ERR] %0t bench timeout", $time);
            report_and_stop();
        end
    end

    task automatic wr(input logic [7:0] idx, input logic [7:0] val, output logic [1:0] r);
        @(posedge sys_clk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, val};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    initial
    begin
        rstIdx = '{gpc_pkg::IDX_OPTION, gpc_pkg::IDX_FIRST_DIR, gpc_pkg::IDX_SECOND_DIR,
            gpc_pkg::IDX_THIRD_DIR, gpc_pkg::IDX_ANALOG_CFG};
        // Third-port direction bits sit at 7,6,2,1,0
        rstVal = '{8'hff, 8'h3f, 8'hff, 8'hc7, 8'h00};
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        waitc(3);
        for (int i = 0; i < 5; i++)
        begin
            rdr(rstIdx[i], rd, resp);
            `CHECK(rd, {24'h0, rstVal[i]})
        end
        `CHECK(firstPortOut, 6'h00)
        `CHECK(secondPortPullupEn, 8'h00)
        // Analog pins read zero until configured digital; bit 4 stays digital
        rdr(gpc_pkg::IDX_FIRST_DATA, rd, resp);
        `CHECK(rd, 32'h10)
        rdr(8'h10, rd, resp);
        `CHECK({rd, resp}, {32'h0, gpc_pkg::RESP_SLVERR})
        wr(8'h10, 8'h55, resp);
        `CHECK(resp, gpc_pkg::RESP_SLVERR)
        wr(gpc_pkg::IDX_ANALOG_CFG, 8'hff, resp);
        rdr(gpc_pkg::IDX_ANALOG_CFG, rd, resp);
        `CHECK(rd, 32'h07)
        rdr(gpc_pkg::IDX_FIRST_DATA, rd, resp);
        `CHECK(rd, 32'h3f)
        wr(gpc_pkg::IDX_FIRST_DIR, 8'hc0, resp);
        rdr(gpc_pkg::IDX_FIRST_DIR, rd, resp);
        `CHECK(rd, 32'h00)
        wr(gpc_pkg::IDX_FIRST_DATA, 8'h3f, resp);
        waitc(1);
        `CHECK({firstPortOut, firstPortOeN}, {6'h2f, 6'h10})
        wr(gpc_pkg::IDX_FIRST_DATA, 8'h00, resp);
        firstPortIn <= 6'h2f;
        waitc(4);
        `CHECK({firstPortOut, firstPortOeN, timerClockPin}, {6'h00, 6'h00, 1'b0})
        // Second port direction, latch and pull-ups
        wr(gpc_pkg::IDX_SECOND_DIR, 8'h0f, resp);
        wr(gpc_pkg::IDX_SECOND_DATA, 8'ha5, resp);
        waitc(1);
        `CHECK({secondPortOeN, secondPortOut}, {8'h0f, 8'ha5})
        `CHECK(secondPortPullupEn, 8'h00)
        wr(gpc_pkg::IDX_OPTION, 8'h7f, resp);
        waitc(1);
        `CHECK(secondPortPullupEn, 8'h0f)
        wr(gpc_pkg::IDX_SECOND_DIR, 8'hff, resp);
        wr(gpc_pkg::IDX_OPTION, 8'hff, resp);
        // Change detection against the snapshot
        rdr(gpc_pkg::IDX_SECOND_DATA, rd, resp);
        wr(gpc_pkg::IDX_INT_CTRL, 8'h18, resp);
        secondPortIn <= 8'h80;
        waitc(5);
        `CHECK({portChangeFlag, wakeFromHalt}, 2'b11)
        wr(gpc_pkg::IDX_INT_CTRL, 8'h18, resp);
        waitc(2);
        `CHECK(portChangeFlag, 1'b1)
        rdr(gpc_pkg::IDX_SECOND_DATA, rd, resp);
        `CHECK(rd, 32'h80)
        wr(gpc_pkg::IDX_INT_CTRL, 8'h18, resp);
        waitc(2);
        `CHECK(portChangeFlag, 1'b0)
        secondPortIn <= 8'h88;
        waitc(5);
        `CHECK(portChangeFlag, 1'b0)
        wr(gpc_pkg::IDX_SECOND_DIR, 8'hbf, resp);
        secondPortIn <= 8'hc8;
        waitc(5);
        `CHECK(portChangeFlag, 1'b0)
        secondPortIn <= 8'h48;
        waitc(5);
        `CHECK(portChangeFlag, 1'b1)
        wr(gpc_pkg::IDX_SECOND_DATA, 8'h00, resp);
        wr(gpc_pkg::IDX_INT_CTRL, 8'h18, resp);
        waitc(2);
        `CHECK(portChangeFlag, 1'b0)
        // External interrupt: rising, then falling selected
        secondPortIn <= 8'h49;
        waitc(5);
        `CHECK({extIntFlag, wakeFromHalt}, 2'b11)
        wr(gpc_pkg::IDX_OPTION, 8'hbf, resp);
        wr(gpc_pkg::IDX_INT_CTRL, 8'h18, resp);
        waitc(2);
        `CHECK(extIntFlag, 1'b0)
        secondPortIn <= 8'h48;
        waitc(5);
        `CHECK(extIntFlag, 1'b1)
        // Third port direction and peripheral override
        wr(gpc_pkg::IDX_THIRD_DIR, 8'h00, resp);
        wr(gpc_pkg::IDX_THIRD_DATA, 8'hc5, resp);
        waitc(1);
        `CHECK({thirdPortOeN, thirdPortOut}, {5'h00, 5'h1d})
        thirdPeriphSel <= 5'h03;
        thirdPeriphDrive <= 5'h01;
        thirdPeriphData <= 5'h02;
        waitc(2);
        `CHECK({thirdPortOeN, thirdPortOut[0], thirdPortOut[4:2]}, {5'h02, 1'b0, 3'h7})
        rdr(gpc_pkg::IDX_THIRD_DIR, rd, resp);
        `CHECK(rd, 32'h00)
        thirdPeriphSel <= 5'h00;
        waitc(2);
        `CHECK(thirdPortOeN, 5'h00)
        // Third-port pins read back at bits 7,6,2,1,0 with the gap reading zero
        thirdPortIn <= 5'h15;
        waitc(3);
        rdr(gpc_pkg::IDX_THIRD_DATA, rd, resp);
        `CHECK(rd, 32'h85)
        report_and_stop();
    end
endmodule
`default_nettype wire
